// ### cmp_consts.svh
// constants for the analog difference comparator
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_ADDR_CTRL     8'h00
`define CMP_ADDR_GAIN     8'h04
`define CMP_ADDR_OFFSET   8'h08
`define CMP_ADDR_ON       8'h0C
`define CMP_ADDR_OFF      8'h10
`define CMP_ADDR_DECIMALS 8'h14
`define CMP_ADDR_STATUS   8'h18
`define CMP_ADDR_DIFF     8'h1C

`define CMP_CTRL_ENABLE   0
`define CMP_CTRL_ON_SRC   1
`define CMP_CTRL_OFF_SRC  2
`define CMP_CTRL_ON_BLK   8
`define CMP_CTRL_OFF_BLK  16

`define CMP_STAT_SWITCH   0
`define CMP_STAT_WINDOW   1

`define CMP_RST_CTRL      32'h0000_0001
`define CMP_RST_GAIN      16'h0064
`define CMP_RST_OFFSET    16'h0000
`define CMP_RST_THRESH    16'h0000
`define CMP_RST_DECIMALS  2'h0

`define CMP_GAIN_SCALE    32'sd100
`define CMP_CYCLE_COUNT   250

`define CMP_RESP_OKAY     2'h0
`define CMP_RESP_SLVERR   2'h2

`endif

// ### cmp_pkg.sv
// types shared by the analog difference comparator
package cmp_pkg;

   typedef struct packed
   {
      logic signed [15:0] gain;
      logic signed [15:0] offset;
      logic signed [15:0] on_thresh;
      logic signed [15:0] off_thresh;
   } params_s;

   typedef struct packed
   {
      logic signed [31:0] on_level;
      logic signed [31:0] off_level;
      logic signed [15:0] first_raw;
      logic signed [15:0] second_raw;
   } sample_s;

   typedef enum logic [1:0]
   {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_e;

   typedef enum logic [1:0]
   {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_e;

endpackage

// ### analog_difference_comparator.sv
// analog difference comparator with axi4-lite register access
//
// Behaviour
// - each raw input is multiplied by the shared gain and the shared offset is added.
// - the difference is scaled first value minus scaled second value, used for all compares.
// - with on >= off the switch output goes to 1 when the difference exceeds on.
// - with on >= off the switch output goes to 0 when the difference is at most off.
// - with on < off the switch output is 1 exactly when on <= difference < off.
// - compares use plain integers; the decimals setting is only stored for display.
// - each threshold is a constant or the actual value of a block chosen by number; a number at or above NUM_PEERS gives 0.
// - the difference is exported as this block's own actual value.
// - analog channels deliver raw values on a 0 to 1000 integer scale for 0 to 10 V.
`timescale 1ns/1ps
`include "cmp_consts.svh"

module analog_difference_comparator
   import cmp_pkg::*;
#(
   parameter int NUM_PEERS   = 16,
   parameter int CYCLE_COUNT = `CMP_CYCLE_COUNT
)
(
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [7:0]                  s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output      logic [1:0]                  s_axi_bresp,
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   input  wire logic [7:0]                  s_axi_araddr,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output      logic [31:0]                 s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   input  wire logic signed [15:0]          first_input_value,
   input  wire logic signed [15:0]          second_input_value,
   input  wire logic [NUM_PEERS-1:0][31:0]  peer_values,
   output      logic                        switch_out,
   output      logic signed [31:0]          actual_value,
   output      logic                        cycle_done
);

   wr_state_e          wr_state;
   rd_state_e          rd_state;
   logic               aw_held;
   logic               w_held;
   logic [7:0]         wr_addr;
   logic [31:0]        wr_data;
   logic [3:0]         wr_strb;
   logic [31:0]        ctrl;
   params_s            par;
   logic [1:0]         decimals;
   logic [31:0]        cycle_cnt;
   logic               tick;
   logic               eval;
   sample_s            smp;
   logic signed [31:0] next_first;
   logic signed [31:0] next_second;
   logic signed [31:0] next_diff;
   logic signed [31:0] on_src;
   logic signed [31:0] off_src;
   logic [7:0]         on_blk;
   logic [7:0]         off_blk;
   logic               wr_fire;
   logic               addr_ok;
   logic [31:0]        merged;

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic map_ok(input logic [7:0] a);
      return (a == `CMP_ADDR_CTRL) || (a == `CMP_ADDR_GAIN) ||
             (a == `CMP_ADDR_OFFSET) || (a == `CMP_ADDR_ON) ||
             (a == `CMP_ADDR_OFF) || (a == `CMP_ADDR_DECIMALS) ||
             (a == `CMP_ADDR_STATUS) || (a == `CMP_ADDR_DIFF);
   endfunction

   // axi write channel: address and data taken in either order
   assign wr_fire = aw_held && w_held && (wr_state == WR_IDLE);
   assign addr_ok = map_ok(wr_addr) && (wr_addr != `CMP_ADDR_STATUS) &&
                    (wr_addr != `CMP_ADDR_DIFF);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         wr_addr       <= 8'h00;
         wr_data       <= 32'h0000_0000;
         wr_strb       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held       <= 1'b1;
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held       <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wr_state     <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CMP_RESP_OKAY;
      end
      else
      begin
         case (wr_state)
            WR_IDLE:
            begin
               if (wr_fire)
               begin
                  wr_state     <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= addr_ok ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
               end
            end
            WR_RESP:
            begin
               if (s_axi_bready)
               begin
                  wr_state     <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default:
            begin
               wr_state     <= WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // parameter registers; range keeping is left to software
   always_comb
   begin
      merged = 32'h0000_0000;
      case (wr_addr)
         `CMP_ADDR_CTRL:     merged = ctrl;
         `CMP_ADDR_GAIN:     merged = {{16{par.gain[15]}}, par.gain};
         `CMP_ADDR_OFFSET:   merged = {{16{par.offset[15]}}, par.offset};
         `CMP_ADDR_ON:       merged = {{16{par.on_thresh[15]}}, par.on_thresh};
         `CMP_ADDR_OFF:      merged = {{16{par.off_thresh[15]}}, par.off_thresh};
         `CMP_ADDR_DECIMALS: merged = {30'h0000_0000, decimals};
         default:            merged = 32'h0000_0000;
      endcase
      merged = apply_strb(merged, wr_data, wr_strb);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctrl           <= `CMP_RST_CTRL;
         par.gain       <= `CMP_RST_GAIN;
         par.offset     <= `CMP_RST_OFFSET;
         par.on_thresh  <= `CMP_RST_THRESH;
         par.off_thresh <= `CMP_RST_THRESH;
         decimals       <= `CMP_RST_DECIMALS;
      end
      else if (wr_fire && addr_ok)
      begin
         case (wr_addr)
            `CMP_ADDR_CTRL:     ctrl           <= merged;
            `CMP_ADDR_GAIN:     par.gain       <= merged[15:0];
            `CMP_ADDR_OFFSET:   par.offset     <= merged[15:0];
            `CMP_ADDR_ON:       par.on_thresh  <= merged[15:0];
            `CMP_ADDR_OFF:      par.off_thresh <= merged[15:0];
            `CMP_ADDR_DECIMALS: decimals       <= merged[1:0];
            default:            ctrl           <= ctrl;
         endcase
      end
   end

   // axi read channel
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rd_state      <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CMP_RESP_OKAY;
      end
      else
      begin
         case (rd_state)
            RD_IDLE:
            begin
               if (s_axi_arvalid)
               begin
                  rd_state      <= RD_DATA;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rresp   <= map_ok(s_axi_araddr) ?
                                   `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
                  case (s_axi_araddr)
                     `CMP_ADDR_CTRL:     s_axi_rdata <= ctrl;
                     `CMP_ADDR_GAIN:
                        s_axi_rdata <= {{16{par.gain[15]}}, par.gain};
                     `CMP_ADDR_OFFSET:
                        s_axi_rdata <= {{16{par.offset[15]}}, par.offset};
                     `CMP_ADDR_ON:
                        s_axi_rdata <= {{16{par.on_thresh[15]}},
                                        par.on_thresh};
                     `CMP_ADDR_OFF:
                        s_axi_rdata <= {{16{par.off_thresh[15]}},
                                        par.off_thresh};
                     `CMP_ADDR_DECIMALS:
                        s_axi_rdata <= {30'h0000_0000, decimals};
                     `CMP_ADDR_STATUS:
                        s_axi_rdata <= {30'h0000_0000,
                                        smp.on_level < smp.off_level,
                                        switch_out};
                     `CMP_ADDR_DIFF:     s_axi_rdata <= actual_value;
                     default:            s_axi_rdata <= 32'h0000_0000;
                  endcase
               end
            end
            RD_DATA:
            begin
               if (s_axi_rready)
               begin
                  rd_state      <= RD_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid  <= 1'b0;
               end
            end
            default:
            begin
               rd_state      <= RD_IDLE;
               s_axi_arready <= 1'b1;
               s_axi_rvalid  <= 1'b0;
            end
         endcase
      end
   end

   // program cycle divider
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cycle_cnt <= 32'h0000_0000;
         tick      <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (cycle_cnt >= 32'(CYCLE_COUNT - 1))
         begin
            cycle_cnt <= 32'h0000_0000;
            tick      <= ctrl[`CMP_CTRL_ENABLE];
         end
         else
         begin
            cycle_cnt <= cycle_cnt + 32'h0000_0001;
         end
      end
   end

   // threshold sources: constant or another block's actual value
   assign on_blk  = ctrl[`CMP_CTRL_ON_BLK +: 8];
   assign off_blk = ctrl[`CMP_CTRL_OFF_BLK +: 8];

   always_comb
   begin
      on_src  = 32'(par.on_thresh);
      off_src = 32'(par.off_thresh);
      if (ctrl[`CMP_CTRL_ON_SRC])
      begin
         on_src = (32'(on_blk) < 32'(NUM_PEERS)) ?
                  signed'(peer_values[on_blk]) : 32'sh0000_0000;
      end
      if (ctrl[`CMP_CTRL_OFF_SRC])
      begin
         off_src = (32'(off_blk) < 32'(NUM_PEERS)) ?
                   signed'(peer_values[off_blk]) : 32'sh0000_0000;
      end
   end

   // sample inputs at the start of each program cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         smp  <= '0;
         eval <= 1'b0;
      end
      else
      begin
         eval <= tick;
         if (tick)
         begin
            smp.first_raw  <= first_input_value;
            smp.second_raw <= second_input_value;
            smp.on_level   <= on_src;
            smp.off_level  <= off_src;
         end
      end
   end

   // gain is in hundredths
   assign next_first  = (32'(smp.first_raw) * 32'(par.gain))
                        / `CMP_GAIN_SCALE + 32'(par.offset);
   assign next_second = (32'(smp.second_raw) * 32'(par.gain))
                        / `CMP_GAIN_SCALE + 32'(par.offset);
   assign next_diff   = next_first - next_second;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         switch_out   <= 1'b0;
         actual_value <= 32'sh0000_0000;
         cycle_done   <= 1'b0;
      end
      else
      begin
         cycle_done <= eval;
         if (eval)
         begin
            actual_value <= next_diff;
            if (smp.on_level >= smp.off_level)
            begin
               if (next_diff > smp.on_level)
               begin
                  switch_out <= 1'b1;
               end
               else if (next_diff <= smp.off_level)
               begin
                  switch_out <= 1'b0;
               end
               else
               begin
                  switch_out <= switch_out;
               end
            end
            else
            begin
               switch_out <= (next_diff >= smp.on_level) &&
                             (next_diff < smp.off_level);
            end
         end
      end
   end

endmodule

// ### cmp_monitor.sv
// port checker for the analog difference comparator
`timescale 1ns/1ps

module cmp_monitor
(
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               switch_out,
   input wire logic signed [31:0] actual_value,
   input wire logic               cycle_done
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_due;
      ##[1:2] s_axi_bvalid;
   endsequence

   property p_b_answer;
      s_wr_taken |-> s_b_due;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_sw_quiet;
      !cycle_done |-> $stable(switch_out);
   endproperty
   property p_val_quiet;
      !cycle_done |-> $stable(actual_value);
   endproperty
   property p_done_pulse;
      cycle_done |=> !cycle_done;
   endproperty

   a_b_answer: assert property (p_b_answer)
      else $error("write response late");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   a_w_block: assert property (p_w_block)
      else $error("write ready during response");
   a_r_answer: assert property (p_r_answer)
      else $error("read data late");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   a_ar_block: assert property (p_ar_block)
      else $error("read ready during data");
   a_sw_quiet: assert property (p_sw_quiet)
      else $error("switch moved off tick");
   a_val_quiet: assert property (p_val_quiet)
      else $error("actual value moved off tick");
   a_done_pulse: assert property (p_done_pulse)
      else $error("tick pulse too long");
endmodule

bind analog_difference_comparator cmp_monitor cmp_monitor_i
(
   .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_rresp, .switch_out, .actual_value, .cycle_done
);

// ### cmp_source.sv
// model of the analog channels and peer blocks feeding the comparator
`timescale 1ns/1ps

module cmp_source
#(
   parameter int NUM_PEERS = 16
)
(
   input  wire logic                       sys_clk,
   output      logic signed [15:0]         first_input_value,
   output      logic signed [15:0]         second_input_value,
   output      logic [NUM_PEERS-1:0][31:0] peer_values
);
   initial
   begin
      first_input_value = '0;
      second_input_value = '0;
      peer_values = '0;
   end

   // millivolts in, 10 V full scale gives 1000 counts
   task automatic set_mv(input int mv1, input int mv2);
      @(posedge sys_clk);
      first_input_value <= 16'(mv1 / 10);
      second_input_value <= 16'(mv2 / 10);
   endtask

   task automatic set_peer(input int idx, input int val);
      @(posedge sys_clk);
      peer_values[idx] <= 32'(val);
   endtask
endmodule

// ### analog_difference_comparator_tb.sv
// self-checking testbench for the analog difference comparator
`timescale 1ns/1ps
`include "cmp_consts.svh"

module analog_difference_comparator_tb
   import cmp_pkg::*;
;
   localparam int CYC = 4;
   localparam int NP = 16;
   localparam int ON_DLY = 6;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, switch_out, cycle_done;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic signed [31:0] actual_value;
   logic signed [15:0] first_input_value, second_input_value;
   logic [NP-1:0][31:0] peer_values;
   int mismatches = 0;
   int n_tests = 0;
   int g_gain = 100;
   int g_off = 0;
   int on_run = 0;

   always #2 sys_clk = ~sys_clk;

   // downstream on-delay stage: counts cycles the switch output stays high
   always @(posedge sys_clk)
      on_run <= (switch_out === 1'b1) ? on_run + 1 : 0;

   analog_difference_comparator #(.NUM_PEERS(NP), .CYCLE_COUNT(CYC))
      analog_difference_comparator_i
   (
      .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .first_input_value,
      .second_input_value, .peer_values, .switch_out, .actual_value,
      .cycle_done
   );

   cmp_source #(.NUM_PEERS(NP)) cmp_source_i
   (
      .sys_clk, .first_input_value, .second_input_value, .peer_values
   );

   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100)
         chk(1'b0, "write hung");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100)
         chk(1'b0, "read hung");
   endtask

   function automatic int exp_diff(input int r1, input int r2);
      return ((r1 * g_gain) / 100 + g_off) - ((r2 * g_gain) / 100 + g_off);
   endfunction

   task automatic wait_done();
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (cycle_done !== 1'b1 && n < 100);
      if (n >= 100)
         chk(1'b0, "no tick");
   endtask

   // second tick is the first one sure to see the new inputs
   task automatic step(input int r1, input int r2, input logic e);
      cmp_source_i.set_mv(r1 * 10, r2 * 10);
      wait_done();
      wait_done();
      chk(switch_out === e, "switch output");
      chk(actual_value === 32'(exp_diff(r1, r2)), "actual value");
   endtask

   task automatic cfg(input int g, input int o, input int on, input int off);
      logic [1:0] r;
      g_gain = g;
      g_off = o;
      wr(`CMP_ADDR_GAIN, 32'(g), r);
      wr(`CMP_ADDR_OFFSET, 32'(o), r);
      wr(`CMP_ADDR_ON, 32'(on), r);
      wr(`CMP_ADDR_OFF, 32'(off), r);
      chk(r === `CMP_RESP_OKAY, "config response");
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] z[4] = '{`CMP_ADDR_OFFSET, `CMP_ADDR_ON, `CMP_ADDR_OFF,
                           `CMP_ADDR_DECIMALS};
      rd(`CMP_ADDR_CTRL, d, r);
      chk(d === `CMP_RST_CTRL && r === `CMP_RESP_OKAY, "ctrl reset");
      rd(`CMP_ADDR_GAIN, d, r);
      chk(d === 32'h0000_0064, "gain reset");
      foreach (z[i])
      begin
         rd(z[i], d, r);
         chk(d === 32'h0000_0000, "zero reset");
      end
      rd(8'h20, d, r);
      chk(d === 32'h0 && r === `CMP_RESP_SLVERR, "unmapped read");
      wr(`CMP_ADDR_STATUS, 32'hFFFF_FFFF, r);
      chk(r === `CMP_RESP_SLVERR, "status write");
      wr(`CMP_ADDR_DIFF, 32'h0000_1234, r);
      chk(r === `CMP_RESP_SLVERR, "diff write");
      s_axi_wstrb <= 4'h2;
      wr(`CMP_ADDR_GAIN, 32'h0000_1200, r);
      s_axi_wstrb <= 4'hF;
      rd(`CMP_ADDR_GAIN, d, r);
      chk(d === 32'h0000_1264, "byte lane write");
   endtask

   task automatic t_hyst();
      int a[5] = '{100, 70, 60, 90, 91};
      logic e[5] = '{1, 1, 0, 0, 1};
      cfg(100, 0, 40, 10);
      foreach (a[i])
         step(a[i], 50, e[i]);
      repeat (ON_DLY + 1) @(posedge sys_clk);
      chk(on_run > ON_DLY, "on-delay stage");
   endtask

   task automatic t_scale();
      cfg(-250, 77, -1000, -2000);
      step(333, 101, 1'b1);
      step(101, 333, 1'b1);
      step(1000, 0, 1'b0);
   endtask

   task automatic t_window();
      int a[5] = '{400, 599, 600, 399, 450};
      logic e[5] = '{1, 1, 0, 0, 1};
      logic [31:0] d;
      logic [1:0] r;
      wr(`CMP_ADDR_DECIMALS, 32'h0000_0003, r);
      cfg(100, 0, -100, 100);
      foreach (a[i])
         step(a[i], 500, e[i]);
      rd(`CMP_ADDR_STATUS, d, r);
      chk(d[1:0] === 2'b11, "status window");
   endtask

   task automatic t_peer();
      logic [1:0] r;
      cfg(100, 0, 0, 10);
      cmp_source_i.set_peer(3, 30);
      wr(`CMP_ADDR_CTRL, 32'h0000_0303, r);
      step(0, 0, 1'b0);
      step(31, 0, 1'b1);
      step(20, 0, 1'b1);
      step(10, 0, 1'b0);
      cmp_source_i.set_peer(3, 50);
      step(45, 0, 1'b0);
      cmp_source_i.set_peer(5, 60);
      wr(`CMP_ADDR_CTRL, 32'h0005_0307, r);
      step(55, 0, 1'b1);
      step(60, 0, 1'b0);
      wr(`CMP_ADDR_CTRL, 32'h0020_0307, r);
      step(60, 0, 1'b1);
      wr(`CMP_ADDR_CTRL, `CMP_RST_CTRL, r);
   endtask

   task automatic t_disable();
      int n;
      logic [1:0] r;
      n = 0;
      wr(`CMP_ADDR_CTRL, 32'h0000_0000, r);
      repeat (2 * CYC) @(posedge sys_clk);
      repeat (5 * CYC)
      begin
         @(posedge sys_clk);
         if (cycle_done === 1'b1)
            n++;
      end
      chk(n == 0, "tick while disabled");
      wr(`CMP_ADDR_CTRL, `CMP_RST_CTRL, r);
      wait_done();
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_hyst();
      t_scale();
      t_window();
      t_peer();
      t_disable();
      close_out();
   end

   initial
   begin
      #80000;
      mismatches++;
      close_out();
   end
endmodule
